// [pkg/sar_adc_pkg.sv]
package sar_adc_pkg;
  // ====================
  // sizes
  localparam int RES_BITS = 10;
  localparam int NUM_CH = 16;
  localparam int CH_W = 4;
  localparam int CYC_W = 9;
  localparam int ADDR_W = 12;
  // ====================
  // timing, figures in converter clock periods
  localparam longint CLK_HZ = 20000000;
  localparam longint BCLK_HZ = 20000000;
  localparam longint CONV_NORM_PER = 299;
  localparam longint CONV_DBL_PER = 173;
  localparam longint CMP_NORM_PER = 47;
  localparam longint CMP_DBL_PER = 29;
  localparam longint STEPS = RES_BITS + 1;
  // least times: round up
  localparam logic [CYC_W-1:0] CONV_NORM_CYC =
    CYC_W'((CONV_NORM_PER * CLK_HZ + BCLK_HZ - 1) / BCLK_HZ);
  localparam logic [CYC_W-1:0] CONV_DBL_CYC =
    CYC_W'((CONV_DBL_PER * CLK_HZ + BCLK_HZ - 1) / BCLK_HZ);
  localparam logic [CYC_W-1:0] CMP_NORM_CYC =
    CYC_W'((CMP_NORM_PER * CLK_HZ + BCLK_HZ - 1) / BCLK_HZ);
  localparam logic [CYC_W-1:0] CMP_DBL_CYC =
    CYC_W'((CMP_DBL_PER * CLK_HZ + BCLK_HZ - 1) / BCLK_HZ);
  // one sample slot plus one slot per result bit
  localparam logic [CYC_W-1:0] CONV_NORM_STEP = CYC_W'(CONV_NORM_CYC / STEPS);
  localparam logic [CYC_W-1:0] CONV_DBL_STEP = CYC_W'(CONV_DBL_CYC / STEPS);
  // ====================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_SINGLE = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_SCAN0 = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_SCAN1 = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_CMPRES = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_CMPREF = 12'h01c;
  localparam logic [ADDR_W-1:0] OFF_RES10 = 12'h040;
  localparam logic [ADDR_W-1:0] OFF_RES8 = 12'h080;
  localparam logic [ADDR_W-1:0] RES_SPAN = 12'h040;
  localparam int IDX_LSB = 2;
  // ====================
  // field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_INSERT = 2;
  localparam int CTRL_RESTART = 3;
  localparam int SGL_CMP = 4;
  localparam int SGL_CHAIN = 5;
  localparam int SCAN0_CONT = 0;
  localparam int CFG_SCAN = 0;
  localparam int CFG_DBL = 1;
  localparam int CFG_HWTRIG = 2;
  localparam int CFG_DMA = 3;
  localparam int ST_BUSY = 0;
  localparam int ST_SCANNING = 1;
  localparam int ST_CH_LSB = 4;
  // scan group codes
  localparam logic [1:0] GRP_4 = 2'h0;
  localparam logic [1:0] GRP_8 = 2'h1;
  localparam logic [CH_W-1:0] LAST_4 = 4'h3;
  localparam logic [CH_W-1:0] LAST_8 = 4'h7;
  localparam logic [CH_W-1:0] LAST_16 = 4'hf;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SINGLE = 2'b01,
    ST_SCAN = 2'b11,
    ST_INSERT = 2'b10
  } seq_state_t;
endpackage

// [pkg/sar_core_if.sv]
`timescale 1ns/1ps
interface sar_core_if;
  logic start;
  logic abort;
  logic comparate;
  logic dbl;
  logic [sar_adc_pkg::CH_W-1:0] chan;
  logic [sar_adc_pkg::RES_BITS-1:0] ref_val;
  logic busy;
  logic done;
  logic done_cmp;
  logic [sar_adc_pkg::CH_W-1:0] done_chan;
  logic [sar_adc_pkg::RES_BITS-1:0] result;
  logic cmp_bit;
  modport seq (output start, abort, comparate, dbl, chan, ref_val,
    input busy, done, done_cmp, done_chan, result, cmp_bit);
  modport core (input start, abort, comparate, dbl, chan, ref_val,
    output busy, done, done_cmp, done_chan, result, cmp_bit);
  modport bank (input done, done_cmp, done_chan, result, cmp_bit);
endinterface

// [core/sar_conv_core.sv]
`timescale 1ns/1ps
module sar_conv_core (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sequencer side
  sar_core_if.core cif,
  // analog side
  input wire logic cmp_above,
  output logic [sar_adc_pkg::CH_W-1:0] mux_sel,
  output logic [sar_adc_pkg::RES_BITS-1:0] dac_code,
  output logic sample_en
);
  localparam int W = sar_adc_pkg::RES_BITS;
  localparam int CW = sar_adc_pkg::CYC_W;
  localparam logic [W-1:0] MSB = {1'b1, {(W-1){1'b0}}};
  logic sync1_reg, sync2_reg;
  logic busy_reg, done_reg, cmp_reg, dbl_reg, cmp_bit_reg;
  logic [CW-1:0] cnt_reg, step_reg, total_c, step_c;
  logic [W-1:0] sar_reg, mask_reg;
  logic [sar_adc_pkg::CH_W-1:0] chan_reg;
  logic tick_c, last_c;
  // ====================
  // comparator input crossing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= cmp_above;
      sync2_reg <= sync1_reg;
    end
  end
  // ====================
  // rate select
  always_comb begin
    if (cmp_reg) begin
      total_c = dbl_reg ? sar_adc_pkg::CMP_DBL_CYC : sar_adc_pkg::CMP_NORM_CYC; // [R12]
    end else begin
      total_c = dbl_reg ? sar_adc_pkg::CONV_DBL_CYC : sar_adc_pkg::CONV_NORM_CYC; // [R11]
    end
    step_c = dbl_reg ? sar_adc_pkg::CONV_DBL_STEP : sar_adc_pkg::CONV_NORM_STEP;
  end
  // slots are wide enough that the two-flop lag settles before a decision
  assign tick_c = busy_reg && !cmp_reg && mask_reg != '0 &&
    step_reg == step_c - 1'b1;
  assign last_c = busy_reg && cnt_reg == total_c - 1'b1;
  // ====================
  // binary search
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      cnt_reg <= '0;
      step_reg <= '0;
      cmp_reg <= 1'b0;
      dbl_reg <= 1'b0;
      chan_reg <= '0;
      sar_reg <= '0;
      mask_reg <= '0;
    end else if (cif.start) begin
      busy_reg <= 1'b1;
      cnt_reg <= '0;
      step_reg <= '0;
      cmp_reg <= cif.comparate;
      dbl_reg <= cif.dbl;
      chan_reg <= cif.chan;
      sar_reg <= cif.comparate ? cif.ref_val : MSB; // [R17]
      mask_reg <= cif.comparate ? '0 : MSB; // [R1]
    end else if (cif.abort) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg + 1'b1;
      step_reg <= (step_reg == step_c - 1'b1) ? '0 : step_reg + 1'b1;
      if (tick_c) begin
        if (sync2_reg) begin
          sar_reg <= sar_reg | (mask_reg >> 1); // [R1]
        end else begin
          sar_reg <= (sar_reg & ~mask_reg) | (mask_reg >> 1);
        end
        mask_reg <= mask_reg >> 1;
      end
      if (last_c) begin
        busy_reg <= 1'b0;
      end
    end
  end
  // ====================
  // completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
      cmp_bit_reg <= 1'b0;
    end else begin
      done_reg <= last_c && !cif.start && !cif.abort;
      if (last_c && cmp_reg) begin
        cmp_bit_reg <= sync2_reg; // [R17]
      end
    end
  end
  assign cif.busy = busy_reg;
  assign cif.done = done_reg;
  assign cif.done_cmp = cmp_reg;
  assign cif.done_chan = chan_reg;
  assign cif.result = sar_reg;
  assign cif.cmp_bit = cmp_bit_reg;
  assign mux_sel = chan_reg;
  assign dac_code = sar_reg;
  assign sample_en = busy_reg && !cmp_reg && cnt_reg < step_c;
endmodule

// [core/sar_result_bank.sv]
`timescale 1ns/1ps
module sar_result_bank (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // completions
  sar_core_if.bank cif,
  // stored results
  output logic [sar_adc_pkg::NUM_CH*sar_adc_pkg::RES_BITS-1:0] res_flat,
  output logic [sar_adc_pkg::NUM_CH-1:0] cmp_flags
);
  localparam int W = sar_adc_pkg::RES_BITS;
  localparam int CHW = sar_adc_pkg::CH_W;
  // ====================
  // one result word and one comparate flag per channel
  for (genvar g = 0; g < sar_adc_pkg::NUM_CH; g++) begin : g_ch
    logic hit;
    assign hit = cif.done && cif.done_chan == CHW'(g);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        res_flat[g*W +: W] <= '0;
        cmp_flags[g] <= 1'b0;
      end else if (hit && !cif.done_cmp) begin
        res_flat[g*W +: W] <= cif.result; // [R16] [R23]
      end else if (hit && cif.done_cmp) begin
        cmp_flags[g] <= cif.cmp_bit; // [R18]
      end
    end
  end
endmodule

// [core/sar_adc_sequencer.sv]
`timescale 1ns/1ps
// Operation
// R1: one ten-bit successive-approximation core shared by sixteen input channels
// R2: software reads each result as ten bits or as eight bits
// R3: comparate kind runs only as single-channel operation, never in scans
// R4: scan converts a group of 4, 8 or 16 channels in turn
// R5: scan runs one pass, or repeats passes until software stops it
// R6: during a scan one single conversion or comparate may be inserted
// R7: a single conversion may be followed automatically by a scan
// R8: a conversion in progress can be restarted from its beginning
// R9: writing one to the start bit begins the configured operation
// R10: a timer event pulse may start conversion instead of software
// R11: full conversion takes at least 299 cycles, 173 at double rate
// R12: rate selectable; comparate takes at least 47 cycles, 29 at double
// R13: request raised on single, comparate, one-shot scan and each scan pass
// R14: single and comparate use the channel of the single control register
// R15: scan group from second scan register, repeat mode from the first
// R16: each result goes to its channel's ten-bit and eight-bit registers
// R17: comparate tests the input against the loaded approximation value
// R18: comparate outcome lands in that channel's bit of comparate flags
// R19: continuous scan halts only when software writes one to stop; the code also halts it at pass end once repeat mode is cleared
// R20: scans start at channel zero and ascend
// R21: after an inserted single, the scan resumes at its suspended channel
// R22: eight-bit view is the top eight bits of the ten-bit result
// R23: a result register holds until the same channel converts again
module sar_adc_sequencer #(
  parameter int RES_BITS = sar_adc_pkg::RES_BITS,
  parameter int NUM_CH = sar_adc_pkg::NUM_CH
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sar_adc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // on-chip timer event
  input wire logic timer_event,
  // analog front end
  input wire logic analog_cmp_above,
  output logic [sar_adc_pkg::CH_W-1:0] analog_mux_sel,
  output logic [sar_adc_pkg::RES_BITS-1:0] analog_dac_code,
  output logic analog_sample,
  // completion requests
  output logic adc_irq,
  output logic adc_dma_req
);
  localparam int W = sar_adc_pkg::RES_BITS;
  localparam int CHW = sar_adc_pkg::CH_W;
  localparam int AW = sar_adc_pkg::ADDR_W;

  if (RES_BITS != sar_adc_pkg::RES_BITS || NUM_CH != sar_adc_pkg::NUM_CH) begin
    $error("sequencer serves only the package sizes");
  end

  sar_core_if cif ();

  logic [CHW-1:0] sgl_ch_reg;
  logic sgl_cmp_reg;
  logic sgl_chain_reg;
  logic scan_cont_reg;
  logic [1:0] scan_grp_reg;
  logic cfg_scan_reg;
  logic cfg_dbl_reg;
  logic cfg_hwtrig_reg;
  logic cfg_dma_reg;
  logic [W-1:0] cmpref_reg;
  logic [31:0] prdata_reg;
  logic err_reg;
  logic irq_reg;
  logic dma_reg;
  sar_adc_pkg::seq_state_t state_reg, state_next;
  logic [CHW-1:0] scan_ch_reg, scan_ch_next, scan_last;
  logic [NUM_CH*W-1:0] res_flat;
  logic [NUM_CH-1:0] cmp_flags;
  logic wr_c, ctrl_wr;
  logic start_req, stop_req, insert_req, restart_req;
  logic go, go_cmp, abort, evt;
  logic [CHW-1:0] go_chan;
  logic [31:0] rd_data;
  logic rd_err;
  logic [CHW-1:0] rd_idx;
  logic [W-1:0] rd_res;

  // ====================
  // apb handshake
  assign pready = psel && penable;
  assign prdata = prdata_reg;
  assign pslverr = psel && penable && err_reg;
  assign wr_c = psel && penable && pwrite;
  assign ctrl_wr = wr_c && paddr == sar_adc_pkg::OFF_CTRL;
  assign start_req = (ctrl_wr && pwdata[sar_adc_pkg::CTRL_START]) || // [R9]
    (cfg_hwtrig_reg && timer_event); // [R10]
  assign stop_req = ctrl_wr && pwdata[sar_adc_pkg::CTRL_STOP];
  assign insert_req = ctrl_wr && pwdata[sar_adc_pkg::CTRL_INSERT];
  assign restart_req = ctrl_wr && pwdata[sar_adc_pkg::CTRL_RESTART];

  // ====================
  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sgl_ch_reg <= '0;
      sgl_cmp_reg <= 1'b0;
      sgl_chain_reg <= 1'b0;
    end else if (wr_c && paddr == sar_adc_pkg::OFF_SINGLE) begin
      sgl_ch_reg <= pwdata[CHW-1:0];
      sgl_cmp_reg <= pwdata[sar_adc_pkg::SGL_CMP];
      sgl_chain_reg <= pwdata[sar_adc_pkg::SGL_CHAIN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_cont_reg <= 1'b0;
    end else if (wr_c && paddr == sar_adc_pkg::OFF_SCAN0) begin
      scan_cont_reg <= pwdata[sar_adc_pkg::SCAN0_CONT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_grp_reg <= sar_adc_pkg::GRP_4;
    end else if (wr_c && paddr == sar_adc_pkg::OFF_SCAN1) begin
      scan_grp_reg <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_scan_reg <= 1'b0;
      cfg_dbl_reg <= 1'b0;
      cfg_hwtrig_reg <= 1'b0;
      cfg_dma_reg <= 1'b0;
    end else if (wr_c && paddr == sar_adc_pkg::OFF_CONFIG) begin
      cfg_scan_reg <= pwdata[sar_adc_pkg::CFG_SCAN];
      cfg_dbl_reg <= pwdata[sar_adc_pkg::CFG_DBL]; // [R12]
      cfg_hwtrig_reg <= pwdata[sar_adc_pkg::CFG_HWTRIG];
      cfg_dma_reg <= pwdata[sar_adc_pkg::CFG_DMA];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpref_reg <= '0;
    end else if (wr_c && paddr == sar_adc_pkg::OFF_CMPREF) begin
      cmpref_reg <= pwdata[W-1:0];
    end
  end

  // ====================
  // scan group end
  always_comb begin
    if (scan_grp_reg == sar_adc_pkg::GRP_4) begin
      scan_last = sar_adc_pkg::LAST_4; // [R4]
    end else if (scan_grp_reg == sar_adc_pkg::GRP_8) begin
      scan_last = sar_adc_pkg::LAST_8;
    end else begin
      scan_last = sar_adc_pkg::LAST_16;
    end
  end

  // ====================
  // sequencer
  // a stop wins in single, scan and insert; restart beats a completion seen in the same cycle
  always_comb begin
    state_next = state_reg;
    scan_ch_next = scan_ch_reg;
    go = 1'b0;
    go_cmp = 1'b0;
    go_chan = sgl_ch_reg; // [R14]
    abort = 1'b0;
    evt = 1'b0;
    case (state_reg)
      sar_adc_pkg::ST_IDLE: begin
        if (start_req) begin
          go = 1'b1;
          if (cfg_scan_reg) begin
            state_next = sar_adc_pkg::ST_SCAN;
            scan_ch_next = '0; // [R20]
            go_chan = '0;
          end else begin
            state_next = sar_adc_pkg::ST_SINGLE;
            go_cmp = sgl_cmp_reg;
          end
        end
      end
      sar_adc_pkg::ST_SINGLE: begin
        if (stop_req) begin
          abort = 1'b1;
          state_next = sar_adc_pkg::ST_IDLE;
        end else if (restart_req) begin
          go = 1'b1; // [R8]
          go_cmp = sgl_cmp_reg;
        end else if (cif.done) begin
          evt = 1'b1; // [R13]
          if (sgl_chain_reg && !cif.done_cmp) begin
            go = 1'b1; // [R7]
            go_chan = '0;
            scan_ch_next = '0;
            state_next = sar_adc_pkg::ST_SCAN;
          end else begin
            state_next = sar_adc_pkg::ST_IDLE; // [R3]
          end
        end
      end
      sar_adc_pkg::ST_SCAN: begin
        if (stop_req) begin
          abort = 1'b1; // [R19]
          state_next = sar_adc_pkg::ST_IDLE;
        end else if (insert_req) begin
          go = 1'b1; // [R6]
          go_cmp = sgl_cmp_reg;
          state_next = sar_adc_pkg::ST_INSERT;
        end else if (restart_req) begin
          go = 1'b1; // [R8]
          go_chan = scan_ch_reg;
        end else if (cif.done) begin
          if (scan_ch_reg == scan_last) begin
            evt = 1'b1; // [R13]
            if (scan_cont_reg) begin
              go = 1'b1; // [R5] [R15]
              go_chan = '0;
              scan_ch_next = '0;
            end else begin
              state_next = sar_adc_pkg::ST_IDLE; // [R5]
            end
          end else begin
            go = 1'b1;
            go_chan = scan_ch_reg + 1'b1; // [R20]
            scan_ch_next = scan_ch_reg + 1'b1;
          end
        end
      end
      sar_adc_pkg::ST_INSERT: begin
        if (stop_req) begin
          abort = 1'b1;
          state_next = sar_adc_pkg::ST_IDLE;
        end else if (restart_req) begin
          go = 1'b1;
          go_cmp = sgl_cmp_reg;
        end else if (cif.done) begin
          evt = 1'b1;
          go = 1'b1;
          go_chan = scan_ch_reg; // [R21]
          state_next = sar_adc_pkg::ST_SCAN;
        end
      end
      default: begin
        state_next = sar_adc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= sar_adc_pkg::ST_IDLE;
      scan_ch_reg <= '0;
    end else begin
      state_reg <= state_next;
      scan_ch_reg <= scan_ch_next;
    end
  end

  // ====================
  // completion requests, routed to cpu or dma
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
      dma_reg <= 1'b0;
    end else begin
      irq_reg <= evt && !cfg_dma_reg; // [R13]
      dma_reg <= evt && cfg_dma_reg;
    end
  end
  assign adc_irq = irq_reg;
  assign adc_dma_req = dma_reg;

  // ====================
  // core and result storage
  assign cif.start = go;
  assign cif.abort = abort;
  assign cif.comparate = go_cmp;
  assign cif.chan = go_chan;
  assign cif.dbl = cfg_dbl_reg;
  assign cif.ref_val = cmpref_reg;

  sar_conv_core u_core (
    .pclk(pclk),
    .presetn(presetn),
    .cif(cif.core),
    .cmp_above(analog_cmp_above),
    .mux_sel(analog_mux_sel),
    .dac_code(analog_dac_code),
    .sample_en(analog_sample)
  );

  sar_result_bank u_bank (
    .pclk(pclk),
    .presetn(presetn),
    .cif(cif.bank),
    .res_flat(res_flat),
    .cmp_flags(cmp_flags)
  );

  // ====================
  // read decode
  localparam int IDX_HI = sar_adc_pkg::IDX_LSB + CHW - 1;
  assign rd_idx = paddr[IDX_HI:sar_adc_pkg::IDX_LSB];
  assign rd_res = res_flat[rd_idx*W +: W];

  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      rd_err = 1'b1;
    end else if (paddr == sar_adc_pkg::OFF_CTRL) begin
      rd_data = '0;
    end else if (paddr == sar_adc_pkg::OFF_SINGLE) begin
      rd_data[CHW-1:0] = sgl_ch_reg;
      rd_data[sar_adc_pkg::SGL_CMP] = sgl_cmp_reg;
      rd_data[sar_adc_pkg::SGL_CHAIN] = sgl_chain_reg;
    end else if (paddr == sar_adc_pkg::OFF_SCAN0) begin
      rd_data[sar_adc_pkg::SCAN0_CONT] = scan_cont_reg;
    end else if (paddr == sar_adc_pkg::OFF_SCAN1) begin
      rd_data[1:0] = scan_grp_reg;
    end else if (paddr == sar_adc_pkg::OFF_CONFIG) begin
      rd_data[sar_adc_pkg::CFG_SCAN] = cfg_scan_reg;
      rd_data[sar_adc_pkg::CFG_DBL] = cfg_dbl_reg;
      rd_data[sar_adc_pkg::CFG_HWTRIG] = cfg_hwtrig_reg;
      rd_data[sar_adc_pkg::CFG_DMA] = cfg_dma_reg;
    end else if (paddr == sar_adc_pkg::OFF_STATUS) begin
      rd_data[sar_adc_pkg::ST_BUSY] = state_reg != sar_adc_pkg::ST_IDLE;
      rd_data[sar_adc_pkg::ST_SCANNING] =
        state_reg == sar_adc_pkg::ST_SCAN ||
        state_reg == sar_adc_pkg::ST_INSERT;
      rd_data[sar_adc_pkg::ST_CH_LSB +: CHW] = scan_ch_reg;
    end else if (paddr == sar_adc_pkg::OFF_CMPRES) begin
      rd_data[NUM_CH-1:0] = cmp_flags; // [R18]
    end else if (paddr == sar_adc_pkg::OFF_CMPREF) begin
      rd_data[W-1:0] = cmpref_reg;
    end else if (paddr >= sar_adc_pkg::OFF_RES10 &&
        paddr < sar_adc_pkg::OFF_RES10 + sar_adc_pkg::RES_SPAN) begin
      rd_data[W-1:0] = rd_res; // [R2]
    end else if (paddr >= sar_adc_pkg::OFF_RES8 &&
        paddr < sar_adc_pkg::OFF_RES8 + sar_adc_pkg::RES_SPAN) begin
      rd_data[7:0] = rd_res[W-1 -: 8]; // [R2] [R22]
    end else begin
      rd_err = 1'b1;
    end
  end

  // read data captured in the setup cycle, so the access phase never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
      err_reg <= 1'b0;
    end else if (psel && !penable) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_data;
      err_reg <= rd_err;
    end
  end
endmodule

// [verif/analog_model.sv]
`timescale 1ns/1ps
// ====================
// analog inputs seen by the converter comparator
module analog_model (
  // converter side
  input wire logic [3:0] mux_sel,
  input wire logic [9:0] dac_code,
  // level bits flipped by the bench, xored in
  input wire logic [9:0] offs,
  output logic cmp_above
);
  logic [9:0] level;
  // equal to the code, with ties read as above, so a clean search lands on it
  assign level = {mux_sel, 6'h2a} ^ offs;
  assign cmp_above = level >= dac_code;
endmodule

// [verif/sar_adc_sequencer_assertions.sv]
`timescale 1ns/1ps
// ====================
// port checks
module sar_adc_sequencer_assertions #(
  parameter int RES_BITS = 10,
  parameter int NUM_CH = 16
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // events and analog
  input wire logic timer_event,
  input wire logic analog_cmp_above,
  input wire logic [3:0] analog_mux_sel,
  input wire logic [RES_BITS-1:0] analog_dac_code,
  input wire logic analog_sample,
  input wire logic adc_irq,
  input wire logic adc_dma_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [9:0] cyc_reg;
  logic full_reg;
  logic pulse;
  assign pulse = adc_irq | adc_dma_req;
  // cycles since the sample window opened
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cyc_reg <= 10'h0;
    else if ($rose(analog_sample))
      cyc_reg <= 10'h1;
    else if (cyc_reg != 10'h3ff)
      cyc_reg <= cyc_reg + 10'h1;
  end
  // a control write may abort, so it voids the timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      full_reg <= 1'b0;
    else if ($rose(analog_sample))
      full_reg <= 1'b1;
    else if (pulse || (psel && penable && pwrite && paddr == 12'h0))
      full_reg <= 1'b0;
  end
  AST_RDY: assert property (pready == (psel && penable))
    else $error("pready not tied to the access phase");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("pslverr outside an access");
  AST_WR_ZERO: assert property (psel && penable && pwrite |-> !prdata)
    else $error("read data not zero on a write");
  AST_PULSE_ONE: assert property (pulse |=> !pulse)
    else $error("completion pulse longer than one cycle");
  AST_ONE_ROUTE: assert property (!(adc_irq && adc_dma_req))
    else $error("irq and dma request together");
  AST_SAMPLE_LEN: assert property ($fell(analog_sample) |->
    cyc_reg == 10'h01b || cyc_reg == 10'h00f)
    else $error("sample window length wrong");
  AST_CONV_TIME: assert property (pulse && full_reg |->
    cyc_reg == 10'h12c || cyc_reg == 10'h0ae)
    else $error("conversion time wrong");
  AST_DAC_MID: assert property ($rose(analog_sample) |->
    analog_dac_code == 10'h200)
    else $error("search does not start at midscale");
  AST_MUX_HOLD: assert property (analog_sample && $past(analog_sample)
    |-> $stable(analog_mux_sel))
    else $error("channel moved in the sample window");
endmodule
bind sar_adc_sequencer sar_adc_sequencer_assertions #(
  .RES_BITS(RES_BITS), .NUM_CH(NUM_CH)) sar_adc_sequencer_assertions_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_event(timer_event),
  .analog_cmp_above(analog_cmp_above), .analog_mux_sel(analog_mux_sel),
  .analog_dac_code(analog_dac_code), .analog_sample(analog_sample),
  .adc_irq(adc_irq), .adc_dma_req(adc_dma_req));

// [verif/tb.sv]
`timescale 1ns/1ps
// ====================
// bench top
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic timer_event = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [9:0] offs = 10'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, cmp, irq, dma, smp;
  logic [3:0] mux;
  logic [9:0] dac;
  int fail_count = 0;
  int checked = 0;
  int cyc;
  always #25 pclk = ~pclk;
  analog_model analog_model_inst (.mux_sel(mux), .dac_code(dac),
    .offs(offs), .cmp_above(cmp));
  sar_adc_sequencer sar_adc_sequencer_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_event(timer_event), .analog_cmp_above(cmp),
    .analog_mux_sel(mux), .analog_dac_code(dac), .analog_sample(smp),
    .adc_irq(irq), .adc_dma_req(dma));
  // ====================
  // helpers
  task automatic test_done;
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bail;
    fail_count++;
    test_done;
  endtask
  task automatic cmp32(string n, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [9:0] vin(int ch);
    return {4'(ch), 6'h2a} ^ offs;
  endfunction
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      if (++n > 20) bail;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(string s, logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp32(s, e, rd);
  endtask
  // one pulse, its wait left in cyc
  task automatic wait_pulse(logic d);
    cyc = 0;
    @(posedge pclk);
    while ((d ? dma : irq) !== 1'b1) begin
      if (++cyc > 6000) bail;
      @(posedge pclk);
    end
  endtask
  task automatic res(int ch);
    logic [9:0] v;
    v = vin(ch);
    rchk("res10", 12'h040 + 12'(4 * ch), {22'h0, v});
    rchk("res8", 12'h080 + 12'(4 * ch), {24'h0, v[9:2]});
  endtask
  // ====================
  // scenarios
  task automatic s_regs;
    apb(1'b1, 12'h01c, 32'h155);
    rchk("cmpref", 12'h01c, 32'h155);
    rchk("unmapped", 12'h020, 32'h0);
    cmp32("slverr", 32'h1, {31'h0, err});
  endtask
  task automatic s_single(int ch, logic [31:0] cfg, logic tm);
    apb(1'b1, 12'h010, cfg);
    apb(1'b1, 12'h004, 32'(ch));
    if (tm) begin
      timer_event <= 1'b1;
      @(posedge pclk);
      timer_event <= 1'b0;
    end else
      apb(1'b1, 12'h000, 32'h1);
    wait_pulse(cfg[3]);
    res(ch);
  endtask
  task automatic s_cmp;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h010, 32'(i % 2 * 2));
      apb(1'b1, 12'h01c, 32'(vin(3)) + 32'(i / 2));
      apb(1'b1, 12'h004, 32'h13);
      apb(1'b1, 12'h000, 32'h1);
      wait_pulse(1'b0);
      rchk("cmpres", 12'h018, 32'(i < 2) << 3);
    end
  endtask
  task automatic s_scan;
    for (int g = 0; g < 3; g++) begin
      offs <= 10'(g + 1);
      apb(1'b1, 12'h010, 32'h1);
      apb(1'b1, 12'h008, 32'h0);
      apb(1'b1, 12'h00c, 32'(g));
      apb(1'b1, 12'h000, 32'h1);
      wait_pulse(1'b0);
      for (int c = 0; c < (4 << g); c++)
        res(c);
      apb(1'b0, 12'h014, 32'h0);
      cmp32("idle", 32'h0, {31'h0, rd[0]});
    end
  endtask
  task automatic s_cont;
    offs <= 10'h3ff;
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h00c, 32'h1);
    apb(1'b1, 12'h000, 32'h1);
    wait_pulse(1'b0);
    // land the insert mid-pass, well past channel zero
    repeat (1150) @(posedge pclk);
    apb(1'b1, 12'h004, 32'hc);
    apb(1'b1, 12'h000, 32'h4);
    wait_pulse(1'b0);
    res(12);
    wait_pulse(1'b0);
    cmp32("resume", 32'h1, 32'(cyc < 1800));
    wait_pulse(1'b0);
    repeat (100) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h2);
    rchk("stopped", 12'h014, 32'h0);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_regs;
    s_single(5, 32'h0, 1'b0);
    s_single(9, 32'he, 1'b1);
    s_cmp;
    s_scan;
    s_cont;
    test_done;
  end
endmodule
